// ===== uomr_pkg.sv
// constants shared by the operand miss refill block
package uomr_pkg;

   // ==========================================================
   // sizes
   localparam int ADDR_W     = 16;
   localparam int WORD_W     = 16;
   localparam int PAGE_W     = 10;
   localparam int FIFO_DEPTH = 8;

   // ==========================================================
   // address manipulation
   localparam int        FLIP_BIT   = 15;
   localparam bit [15:0] FLIP_MASK  = 16'h8000;
   localparam bit [15:0] NEXT_WORD  = 16'h0001;
   localparam bit [15:0] EVEN_MASK  = 16'hfffe;

   // ==========================================================
   // reset values
   localparam bit [15:0] RST_ADDR   = 16'h0000;
   localparam bit [15:0] RST_WORD   = 16'h0000;

   // ==========================================================
   // refill sequence states, gray along the unaligned path
   typedef enum logic [2:0] {
      UOMR_IDLE  = 3'h0,
      UOMR_REQ1  = 3'h1,
      UOMR_FILL1 = 3'h3,
      UOMR_REQ2  = 3'h2,
      UOMR_FILL2 = 3'h6,
      UOMR_DONE  = 3'h4
   } uomr_state_e;

endpackage

// ===== uomr_refill.sv
// operand miss refill controller and its fill data fifo
`timescale 1ns/100ps
// ==========================================================

// ==========================================================
// fill fifo
module uomr_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clock_in,
   input  wire logic             resetn_in,
   input  wire logic             enable_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << PW) != DEPTH) begin
         $error("fifo depth must be a power of two of at least 2");
      end
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [PW:0]      cnt_ff, nxt_cnt;
   logic             ready_ff, nxt_ready;
   logic             push, pop;

   always_comb begin
      push      = in_valid_in && ready_ff;
      pop       = out_ready_in && (cnt_ff != '0);
      nxt_wr    = push ? PW'(wr_ff + 1'b1) : wr_ff;
      nxt_rd    = pop ? PW'(rd_ff + 1'b1) : rd_ff;
      nxt_cnt   = (PW+1)'(cnt_ff + {{PW{1'b0}}, push}
                  - {{PW{1'b0}}, pop});
      nxt_ready = nxt_cnt != (PW+1)'(DEPTH);
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ff    <= '0;
         rd_ff    <= '0;
         cnt_ff   <= '0;
         ready_ff <= 1'b1;
      end else if (enable_in) begin
         wr_ff    <= nxt_wr;
         rd_ff    <= nxt_rd;
         cnt_ff   <= nxt_cnt;
         ready_ff <= nxt_ready;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_ent
         always_ff @(posedge clock_in) begin
            if (enable_in && push && wr_ff == PW'(gi)) begin
               mem_ff[gi] <= in_data_in;
            end
         end
      end
   endgenerate

   assign in_ready_out  = ready_ff;
   assign out_valid_out = cnt_ff != '0;
   assign out_data_out  = mem_ff[rd_ff];
endmodule // uomr_fifo

// ==========================================================
// refill controller
module uomr_refill #(
   parameter int ADDR_W     = uomr_pkg::ADDR_W,
   parameter int WORD_W     = uomr_pkg::WORD_W,
   parameter int PAGE_W     = uomr_pkg::PAGE_W,
   parameter int FIFO_DEPTH = uomr_pkg::FIFO_DEPTH
) (
   input  wire logic                clock_in,
   input  wire logic                resetn_in,
   input  wire logic                enable_in,
   input  wire logic                miss_in,
   input  wire logic [ADDR_W-1:0]   effective_address_in,
   input  wire logic [ADDR_W-1:0]   instruction_prefetch_ptr_in,
   input  wire logic [ADDR_W-PAGE_W-1:0] phys_frame_in,
   input  wire logic                mem_data_valid_in,
   input  wire logic [2*WORD_W-1:0] mem_data_bus_in,
   output logic                     mem_data_ready_out,
   output logic [ADDR_W-1:0]        mem_address_bus_out,
   output logic                     mem_address_valid_out,
   output logic                     fetch_hold_out,
   output logic                     global_hold_out,
   output logic [ADDR_W-1:0]        virtual_address_select_out,
   output logic                     cache_write_out,
   output logic [ADDR_W-1:0]        cache_write_addr_out,
   output logic [2*WORD_W-1:0]      cache_write_data_out,
   output logic [WORD_W-1:0]        opcode_word_reg_out,
   output logic [WORD_W-1:0]        displacement_word_reg_out,
   output logic [ADDR_W-1:0]        saved_operand_addr_reg_out,
   output logic                     operand_valid_out
);
   initial begin
      if (ADDR_W != 16 || PAGE_W < 1 || PAGE_W >= ADDR_W) begin
         $error("address must be 16 bits with a page inside it");
      end
   end

   // ==========================================================
   // fill data buffering
   logic                f_valid, f_pop, f_ready;
   logic [2*WORD_W-1:0] f_data;

   uomr_fifo #(.WIDTH(2*WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock_in      (clock_in),
      .resetn_in     (resetn_in),
      .enable_in     (enable_in),
      .in_valid_in   (mem_data_valid_in),
      .in_ready_out  (f_ready),
      .in_data_in    (mem_data_bus_in),
      .out_valid_out (f_valid),
      .out_ready_in  (f_pop),
      .out_data_out  (f_data)
   );
   assign mem_data_ready_out = f_ready;

   // ==========================================================
   // sequence state
   uomr_pkg::uomr_state_e state_ff, nxt_state;
   logic [ADDR_W-1:0]     ea_ff, nxt_ea, saved_operand_addr_reg_ff, nxt_saved_operand_addr_reg;
   logic [ADDR_W-1:0]     mab_ff, nxt_mab, sel_ff, nxt_sel;
   logic [ADDR_W-1:0]     cwa_ff, nxt_cwa, saved_operand_addr_reg_p1;
   logic [2*WORD_W-1:0]   cwd_ff, nxt_cwd;
   logic [WORD_W-1:0]     op_ff, nxt_op, disp_ff, nxt_disp;
   logic                  mav_ff, nxt_mav, hold_ff, nxt_hold;
   logic                  cwe_ff, nxt_cwe, ov_ff, nxt_ov;

   function automatic logic [ADDR_W-1:0] xlate(logic [ADDR_W-1:0] va,
         logic [ADDR_W-PAGE_W-1:0] frame);
      xlate = {frame, va[PAGE_W-1:0]};
   endfunction

   assign saved_operand_addr_reg_p1 = ADDR_W'(saved_operand_addr_reg_ff + uomr_pkg::NEXT_WORD);

   always_comb begin
      nxt_state = state_ff;
      nxt_ea    = ea_ff;
      nxt_saved_operand_addr_reg  = saved_operand_addr_reg_ff;
      nxt_mab   = mab_ff;
      nxt_sel   = sel_ff;
      nxt_cwa   = cwa_ff;
      nxt_cwd   = cwd_ff;
      nxt_op    = op_ff;
      nxt_disp  = disp_ff;
      nxt_mav   = 1'b0;
      nxt_hold  = hold_ff;
      nxt_cwe   = 1'b0;
      nxt_ov    = 1'b0;
      f_pop     = 1'b0;
      case (state_ff)
         uomr_pkg::UOMR_IDLE: begin
            nxt_sel = instruction_prefetch_ptr_in;
            if (miss_in) begin
               nxt_ea    = effective_address_in;
               nxt_saved_operand_addr_reg  = effective_address_in;
               nxt_sel   = effective_address_in;
               nxt_hold  = 1'b1;
               nxt_state = uomr_pkg::UOMR_REQ1;
            end
         end
         uomr_pkg::UOMR_REQ1: begin
            nxt_mab   = xlate(saved_operand_addr_reg_ff, phys_frame_in);
            nxt_mav   = 1'b1;
            nxt_state = uomr_pkg::UOMR_FILL1;
         end
         uomr_pkg::UOMR_FILL1: begin
            // latency is open ended: simply wait for fill data
            f_pop = 1'b1;
            if (f_valid) begin
               nxt_cwe = 1'b1;
               nxt_cwa = saved_operand_addr_reg_ff & uomr_pkg::EVEN_MASK;
               nxt_cwd = f_data;
               nxt_op  = f_data[WORD_W-1:0];
               nxt_disp = f_data[2*WORD_W-1:WORD_W];
               if (saved_operand_addr_reg_ff[0]) begin
                  // odd word is first operand word; opcode slot bad
                  nxt_op    = f_data[2*WORD_W-1:WORD_W];
                  nxt_state = uomr_pkg::UOMR_REQ2;
               end else begin
                  nxt_state = uomr_pkg::UOMR_DONE;
               end
            end
         end
         uomr_pkg::UOMR_REQ2: begin
            nxt_sel   = ea_ff ^ uomr_pkg::FLIP_MASK;
            nxt_mab   = xlate(saved_operand_addr_reg_p1, phys_frame_in);
            nxt_mav   = 1'b1;
            nxt_state = uomr_pkg::UOMR_FILL2;
         end
         uomr_pkg::UOMR_FILL2: begin
            f_pop = 1'b1;
            if (f_valid) begin
               nxt_sel = saved_operand_addr_reg_p1;
               nxt_cwe = 1'b1;
               nxt_cwa = saved_operand_addr_reg_p1 & uomr_pkg::EVEN_MASK;
               nxt_cwd = f_data;
               nxt_op  = f_data[WORD_W-1:0];
               nxt_state = uomr_pkg::UOMR_DONE;
            end
         end
         uomr_pkg::UOMR_DONE: begin
            nxt_sel   = instruction_prefetch_ptr_in;
            nxt_hold  = 1'b0;
            nxt_ov    = 1'b1;
            nxt_state = uomr_pkg::UOMR_IDLE;
         end
         default: begin
            nxt_hold  = 1'b0;
            nxt_state = uomr_pkg::UOMR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_ff <= uomr_pkg::UOMR_IDLE;
         ea_ff    <= uomr_pkg::RST_ADDR;
         saved_operand_addr_reg_ff  <= uomr_pkg::RST_ADDR;
         mab_ff   <= uomr_pkg::RST_ADDR;
         sel_ff   <= uomr_pkg::RST_ADDR;
         cwa_ff   <= uomr_pkg::RST_ADDR;
         cwd_ff   <= {uomr_pkg::RST_WORD, uomr_pkg::RST_WORD};
         op_ff    <= uomr_pkg::RST_WORD;
         disp_ff  <= uomr_pkg::RST_WORD;
         mav_ff   <= 1'b0;
         hold_ff  <= 1'b0;
         cwe_ff   <= 1'b0;
         ov_ff    <= 1'b0;
      end else if (enable_in) begin
         state_ff <= nxt_state;
         ea_ff    <= nxt_ea;
         saved_operand_addr_reg_ff  <= nxt_saved_operand_addr_reg;
         mab_ff   <= nxt_mab;
         sel_ff   <= nxt_sel;
         cwa_ff   <= nxt_cwa;
         cwd_ff   <= nxt_cwd;
         op_ff    <= nxt_op;
         disp_ff  <= nxt_disp;
         mav_ff   <= nxt_mav;
         hold_ff  <= nxt_hold;
         cwe_ff   <= nxt_cwe;
         ov_ff    <= nxt_ov;
      end
   end

   assign mem_address_bus_out        = mab_ff;
   assign mem_address_valid_out      = mav_ff;
   assign fetch_hold_out             = hold_ff;
   assign global_hold_out            = hold_ff;
   assign virtual_address_select_out = sel_ff;
   assign cache_write_out            = cwe_ff;
   assign cache_write_addr_out       = cwa_ff;
   assign cache_write_data_out       = cwd_ff;
   assign opcode_word_reg_out        = op_ff;
   assign displacement_word_reg_out  = disp_ff;
   assign saved_operand_addr_reg_out = saved_operand_addr_reg_ff;
   assign operand_valid_out          = ov_ff;

   // ==========================================================
   // checks
   sequence s_fill2_pop;
      enable_in && state_ff == uomr_pkg::UOMR_FILL2 && f_valid;
   endsequence
   sequence s_done_step;
      enable_in && state_ff == uomr_pkg::UOMR_DONE;
   endsequence

   chk_hold_on_miss: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      enable_in && state_ff == uomr_pkg::UOMR_IDLE && miss_in |=>
         fetch_hold_out && global_hold_out)
      else $error("holds not raised on miss");
   chk_wait_fill: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      enable_in && state_ff == uomr_pkg::UOMR_FILL1 && !f_valid |=>
         state_ff == uomr_pkg::UOMR_FILL1 && fetch_hold_out)
      else $error("left first fill wait without data");
   chk_addr_sent: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      enable_in && state_ff == uomr_pkg::UOMR_REQ1 |=>
         mem_address_valid_out && mem_address_bus_out ==
         {$past(phys_frame_in), saved_operand_addr_reg_ff[PAGE_W-1:0]})
      else $error("miss address not translated onto bus");
   chk_no_valid_hold: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      fetch_hold_out |-> !operand_valid_out)
      else $error("operand marked valid during miss");
   chk_flip_bit: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      enable_in && state_ff == uomr_pkg::UOMR_REQ2 |=>
         virtual_address_select_out == (ea_ff ^ uomr_pkg::FLIP_MASK))
      else $error("second double-word select lacks bit 15 flip");
   chk_even_write: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      cache_write_out && $past(enable_in) |-> !cache_write_addr_out[0] &&
         $past(f_valid) && $past(f_pop))
      else $error("fill not written as even odd pair");
   chk_replace_op: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      s_fill2_pop |=> opcode_word_reg_out ==
         $past(f_data[WORD_W-1:0]) ##1 operand_valid_out)
      else $error("unaligned opcode word not replaced");
   chk_second_addr: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      enable_in && state_ff == uomr_pkg::UOMR_REQ2 |=>
         mem_address_bus_out[PAGE_W-1:0] ==
         ADDR_W'(saved_operand_addr_reg_ff + uomr_pkg::NEXT_WORD) % (1 << PAGE_W))
      else $error("second fill not at saved address plus one");
   chk_resume_ptr: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      s_done_step |=> virtual_address_select_out ==
         $past(instruction_prefetch_ptr_in) && !fetch_hold_out)
      else $error("select did not return to prefetch pointer");
endmodule // uomr_refill

// ===== uomr_mem_model.sv
// behavioural memory controller answering refill address requests
`timescale 1ns/100ps
module uomr_mem_model (
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   input  wire logic        enable_in,
   input  wire logic        addr_valid_in,
   input  wire logic [15:0] addr_in,
   input  wire logic        ready_in,
   input  wire logic [7:0]  latency_in,
   input  wire logic        ecc_in,
   output logic             valid_out,
   output logic [31:0]      data_out
);
   logic [15:0] req_q[$];
   logic [15:0] a;
   bit          skip_next;

   function automatic logic [15:0] word(input logic [15:0] adr);
      return adr ^ 16'h5a3c;
   endfunction

   task automatic send(input logic [15:0] even);
      valid_out <= 1'b1;
      data_out  <= {word(even + 16'h0001), word(even)};
      do @(posedge clock_in); while (!(ready_in && enable_in));
      valid_out <= 1'b0;
      data_out  <= ~data_out;
   endtask

   initial begin
      valid_out = 1'b0;
      data_out  = 32'h0000_0000;
   end

   // ==========================================================
   // an odd address is served with both pairs, so its follow-up is skipped
   always @(posedge clock_in) begin
      if (!resetn_in) begin
         req_q.delete();
         skip_next = 1'b0;
      end else if (addr_valid_in && enable_in) begin
         if (skip_next) begin
            skip_next = 1'b0;
         end else begin
            req_q.push_back(addr_in);
            skip_next = addr_in[0];
         end
      end
   end

   always begin
      @(posedge clock_in);
      if (req_q.size() != 0) begin
         a = req_q.pop_front();
         repeat (latency_in) @(posedge clock_in);
         send(a & 16'hfffe);
         if (a[0]) begin
            repeat (ecc_in ? 3 : 1) @(posedge clock_in);
            send((a & 16'hfffe) + 16'h0002);
         end
      end
   end
endmodule // uomr_mem_model

// ===== test_unaligned_operand_miss_refill.sv
// self-checking bench for the operand miss refill controller
`timescale 1ns/100ps
module test_unaligned_operand_miss_refill;
   logic        clock_in, resetn_in, enable_in, miss_in, ecc, mvalid;
   logic        ready, mav, hold, global_hold, cwr, ov;
   logic [15:0] ea, instruction_prefetch_ptr, bus, sel, cwa, op, dp, sav;
   logic [5:0]  frame;
   logic [7:0]  lat;
   logic [31:0] mdata, cwd;
   int          failures, num_checks, hold_bad;
   bit          flip, nxt;
   logic [31:0] bus_q[$], wa_q[$], wd_q[$], op_q[$], dp_q[$], sl_q[$];
   logic [31:0] hd_q[$], fl_q[$], nx_q[$], sv_q[$];

   uomr_refill uut (.clock_in(clock_in), .resetn_in(resetn_in),
      .enable_in(enable_in), .miss_in(miss_in), .effective_address_in(ea),
      .instruction_prefetch_ptr_in(instruction_prefetch_ptr), .phys_frame_in(frame),
      .mem_data_valid_in(mvalid), .mem_data_bus_in(mdata),
      .mem_data_ready_out(ready), .mem_address_bus_out(bus),
      .mem_address_valid_out(mav), .fetch_hold_out(hold),
      .global_hold_out(global_hold), .virtual_address_select_out(sel),
      .cache_write_out(cwr), .cache_write_addr_out(cwa),
      .cache_write_data_out(cwd), .opcode_word_reg_out(op),
      .displacement_word_reg_out(dp), .saved_operand_addr_reg_out(sav),
      .operand_valid_out(ov));

   uomr_mem_model mem (.clock_in(clock_in), .resetn_in(resetn_in),
      .enable_in(enable_in), .addr_valid_in(mav), .addr_in(bus),
      .ready_in(ready), .latency_in(lat), .ecc_in(ecc),
      .valid_out(mvalid), .data_out(mdata));

   function automatic logic [15:0] word(input logic [15:0] adr);
      return adr ^ 16'h5a3c;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================================
   // monitor: one record per bus request and per cache write, one operand record per refill
   always @(posedge clock_in) begin
      if (resetn_in && enable_in) begin
         if (mav) bus_q.push_back(32'(bus));
         if (cwr) begin
            wa_q.push_back(32'(cwa));
            wd_q.push_back(cwd);
            if (!hold) hold_bad++;
         end
         if (hold && sel === (ea ^ uomr_pkg::FLIP_MASK)) flip = 1'b1;
         if (hold && sel === ea + uomr_pkg::NEXT_WORD) nxt = 1'b1;
         if (ov) begin
            op_q.push_back(32'(op));
            dp_q.push_back(32'(dp));
            sl_q.push_back(32'(sel));
            hd_q.push_back(32'({hold, global_hold}));
            sv_q.push_back(32'(sav));
            fl_q.push_back(32'(flip));
            nx_q.push_back(32'(nxt));
            flip = 1'b0;
            nxt = 1'b0;
         end
      end
   end

   // ==========================================================
   // shared steps
   task automatic start(input logic [15:0] adr, input logic [7:0] l,
                        input logic e);
      @(posedge clock_in);
      miss_in <= 1'b1;
      ea <= adr;
      lat <= l;
      ecc <= e;
      @(posedge clock_in);
      miss_in <= 1'b0;
   endtask

   task automatic finish(input logic [15:0] adr);
      logic [15:0] pa, e;
      int n;
      pa = {frame, adr[9:0]};
      e = pa & uomr_pkg::EVEN_MASK;
      n = 0;
      while (op_q.size() == 0 && n < 400) begin
         @(negedge clock_in);
         n++;
      end
      if (op_q.size() == 0) begin
         failures++;
         $display("unexpected at %0t: no operand", $time);
         summarize();
      end
      check(bus_q.pop_front(), 32'(pa));
      check(wa_q.pop_front(), 32'(adr & uomr_pkg::EVEN_MASK));
      check(wd_q.pop_front(), {word(e + 16'h1), word(e)});
      check(dp_q.pop_front(), 32'(word(e + 16'h1)));
      check(sl_q.pop_front(), 32'(instruction_prefetch_ptr));
      check(hd_q.pop_front(), 32'h0);
      check(sv_q.pop_front(), 32'(adr));
      if (adr[0]) begin
         check(bus_q.pop_front(), 32'(pa + 16'h1));
         check(wa_q.pop_front(), 32'(adr + 16'h1));
         check(wd_q.pop_front(), {word(e + 16'h3), word(e + 16'h2)});
         check(op_q.pop_front(), 32'(word(e + 16'h2)));
         check(fl_q.pop_front(), 32'h1);
         check(nx_q.pop_front(), 32'h1);
      end else begin
         check(op_q.pop_front(), 32'(word(e)));
         void'(fl_q.pop_front());
         void'(nx_q.pop_front());
      end
   endtask

   task automatic settle(input string name);
      repeat (8) @(negedge clock_in);
      check(32'(op_q.size() + bus_q.size()), 32'h0);
      check(32'(hold_bad), 32'h0);
      check(32'(ready), 32'h1);
      $display("test %s done", name);
   endtask

   // ==========================================================
   // scenarios
   task automatic aligned_fast();
      frame <= 6'h15;
      instruction_prefetch_ptr <= 16'h0506;
      start(16'h0104, 8'h00, 1'b0);
      finish(16'h0104);
      settle("aligned_fast");
   endtask

   task automatic unaligned_two_beats();
      frame <= 6'h2a;
      instruction_prefetch_ptr <= 16'h1510;
      start(16'h0101, 8'h01, 1'b0);
      finish(16'h0101);
      settle("unaligned_two_beats");
   endtask

   task automatic unaligned_ecc_slow();
      frame <= 6'h3f;
      instruction_prefetch_ptr <= 16'h7ffe;
      start(16'h82a7, 8'h19, 1'b1);
      finish(16'h82a7);
      settle("unaligned_ecc_slow");
   endtask

   task automatic frozen_refill();
      frame <= 6'h01;
      instruction_prefetch_ptr <= 16'h0040;
      start(16'h03f1, 8'h03, 1'b0);
      enable_in <= 1'b0;
      repeat (3) @(negedge clock_in);
      check(32'({hold, global_hold}), 32'h3);
      @(posedge clock_in);
      enable_in <= 1'b1;
      finish(16'h03f1);
      settle("frozen_refill");
   endtask

   task automatic back_to_back();
      int n;
      frame <= 6'h0c;
      instruction_prefetch_ptr <= 16'h1234;
      @(posedge clock_in);
      miss_in <= 1'b1;
      ea <= 16'h0010;
      lat <= 8'h02;
      n = 0;
      while (hold !== 1'b1 && n < 20) begin
         @(negedge clock_in);
         n++;
      end
      @(posedge clock_in);
      ea <= 16'h0133;
      finish(16'h0010);
      @(posedge clock_in);
      miss_in <= 1'b0;
      finish(16'h0133);
      settle("back_to_back");
   endtask

   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end

   initial begin
      #(5 * 20000);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      summarize();
   end

   initial begin
      {resetn_in, miss_in, ecc} = 3'h0;
      enable_in = 1'b1;
      {ea, instruction_prefetch_ptr, lat, frame} = 46'h0;
      repeat (2) @(posedge clock_in);
      resetn_in <= 1'b1;
      aligned_fast();
      unaligned_two_beats();
      unaligned_ecc_slow();
      frozen_refill();
      back_to_back();
      summarize();
   end
endmodule // test_unaligned_operand_miss_refill
